// [ptc_defines.svh]
// constants for the pulse timer/counter input block
`ifndef PTC_DEFINES_SVH
`define PTC_DEFINES_SVH
`define PTC_CLK_PERIOD_NS 50
`define PTC_FLT_100NS 100
`define PTC_FLT_200NS 200
`define PTC_FLT_500NS 500
`define PTC_FLT_1US 1000
`define PTC_FLT_2US 2000
`define PTC_FLT_5US 5000
`define PTC_RPM_SECONDS 60
`define PTC_MAX_PPR 32767
`define PTC_CNT_RESET 32'h0000_0000
`endif

// [ptc_pkg.sv]
// types for the pulse timer/counter input block
package ptc_pkg;
    typedef enum logic [1:0] {
        PTC_UNI,
        PTC_BI,
        PTC_QUAD
    } ptc_coupling_t;
    typedef enum logic [1:0] {
        PTC_RST_MANUAL,
        PTC_RST_START,
        PTC_RST_FIRST,
        PTC_RST_EACH
    } ptc_rst_mode_t;
    typedef struct packed {
        logic sig;
        logic rst;
        logic dir;
    } ptc_pins_t;
    typedef struct packed {
        ptc_coupling_t coupling;
        ptc_rst_mode_t rst_mode;
        logic [2:0] filter_sel;
        logic rst_invert;
        logic angle_mode;
        logic [14:0] max_angle;
        logic [14:0] ref_angle;
        logic [15:0] interval;
    } ptc_cfg_t;
    typedef struct packed {
        logic [31:0] count;
        logic [31:0] delta;
        logic [31:0] dt_ticks;
        logic valid;
    } ptc_result_t;
endpackage

// [ptc_counter.sv]
// pulse timer/counter input: filter, decode, reset policy, interval measurement
`timescale 1ns/10ps
`include "ptc_defines.svh"

// Overview of operation
// - three inputs: signal, reset, direction
// - uni, bi, or quadrature coupling selectable
// - angle result spans zero to full turn
// - speed is delta count over interval
// - interval selectable, one sample upward
// - direction used in bi-directional, and as phase B in quadrature
// - six selectable minimum pulse widths
// - reset input polarity is selectable
// - manual option clears on software command
// - start option loads zero at recording start
// - first-pulse option clears once per recording start
// - each-pulse option clears every pulse
// - direction low counts up, high down
// - angle wraps at maximum angle count
// - angle reset loads reference angle
// - pulses per rotation up to 32767
module ptc_counter
    import ptc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire ptc_pins_t pins_i,
    input wire ptc_cfg_t cfg_i,
    input wire logic sample_i,
    input wire logic rec_start_i,
    input wire logic sw_clear_i,
    output ptc_result_t result_o,
    output logic dir_neg_o
);
    localparam int NCH = 3;
    // filter thresholds in clock cycles, rounded up
    localparam int F0 = (`PTC_FLT_100NS + `PTC_CLK_PERIOD_NS - 1) / `PTC_CLK_PERIOD_NS;
    localparam int F1 = (`PTC_FLT_200NS + `PTC_CLK_PERIOD_NS - 1) / `PTC_CLK_PERIOD_NS;
    localparam int F2 = (`PTC_FLT_500NS + `PTC_CLK_PERIOD_NS - 1) / `PTC_CLK_PERIOD_NS;
    localparam int F3 = (`PTC_FLT_1US + `PTC_CLK_PERIOD_NS - 1) / `PTC_CLK_PERIOD_NS;
    localparam int F4 = (`PTC_FLT_2US + `PTC_CLK_PERIOD_NS - 1) / `PTC_CLK_PERIOD_NS;
    localparam int F5 = (`PTC_FLT_5US + `PTC_CLK_PERIOD_NS - 1) / `PTC_CLK_PERIOD_NS;

    // threshold lookup, shared by all three filter channels
    function automatic logic [7:0] flt_len(input logic [2:0] sel);
        if (sel == 3'h0) flt_len = 8'(F0);
        else if (sel == 3'h1) flt_len = 8'(F1);
        else if (sel == 3'h2) flt_len = 8'(F2);
        else if (sel == 3'h3) flt_len = 8'(F3);
        else if (sel == 3'h4) flt_len = 8'(F4);
        else flt_len = 8'(F5);
    endfunction

    logic [NCH-1:0] raw; // the three shared event pins
    logic [NCH-1:0] filt; // debounced levels
    assign raw = {pins_i.sig, pins_i.rst ^ cfg_i.rst_invert, pins_i.dir};

    // each channel follows its pin only after it held the new level long enough
    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_flt
            logic [7:0] run_reg, run_next;
            logic lvl_reg, lvl_next;
            always_comb begin
                run_next = 8'h00;
                lvl_next = lvl_reg;
                if (raw[g] != lvl_reg) begin
                    run_next = run_reg + 8'h01;
                    if (run_next >= flt_len(cfg_i.filter_sel)) begin
                        lvl_next = raw[g];
                        run_next = 8'h00;
                    end
                end
            end
            always_ff @(posedge core_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    run_reg <= 8'h00;
                    lvl_reg <= 1'b0;
                end else begin
                    run_reg <= run_next;
                    lvl_reg <= lvl_next;
                end
            end
            assign filt[g] = lvl_reg;
        end
    endgenerate

    // edge detection on filtered levels
    logic sig_d_reg, rst_d_reg, dir_d_reg;
    logic sig_rise, rst_rise, dir_edge;
    assign sig_rise = filt[2] & ~sig_d_reg;
    assign rst_rise = filt[1] & ~rst_d_reg;
    assign dir_edge = filt[0] ^ dir_d_reg;

    // count state
    logic [31:0] cnt_reg, cnt_next;
    logic armed_reg, armed_next; // first-pulse reset still pending
    logic [15:0] smp_reg, smp_next; // samples into current interval
    logic [31:0] tick_reg, tick_next; // free 20 MHz timebase
    logic [31:0] t_first_reg, t_first_next, t_last_reg, t_last_next;
    logic [31:0] c_first_reg, c_first_next;
    logic got_edge_reg, got_edge_next;
    ptc_result_t res_reg, res_next;
    logic neg_reg, neg_next;
    logic signed [1:0] step;
    logic do_clear, do_refload;

    // step from coupling; quadrature uses signal/direction as phases A/B
    always_comb begin
        step = 2'sd0;
        case (cfg_i.coupling)
            PTC_UNI: if (sig_rise) step = 2'sd1;
            PTC_BI: if (sig_rise) step = filt[0] ? -2'sd1 : 2'sd1;
            PTC_QUAD: begin
                if (sig_rise || dir_edge || (sig_d_reg && !filt[2])) begin
                    if ((filt[2] ^ sig_d_reg) && !dir_edge)
                        step = (filt[2] ^ filt[0]) ? 2'sd1 : -2'sd1;
                    else if (dir_edge && !(filt[2] ^ sig_d_reg))
                        step = (filt[2] ^ filt[0]) ? -2'sd1 : 2'sd1;
                end
            end
            default: step = 2'sd0;
        endcase
    end

    // reset policy; a clear overrides a step taken in the same cycle
    always_comb begin
        do_clear = 1'b0;
        armed_next = armed_reg;
        case (cfg_i.rst_mode)
            PTC_RST_MANUAL: do_clear = sw_clear_i;
            PTC_RST_START: do_clear = rec_start_i;
            PTC_RST_FIRST: if (rst_rise && armed_reg) begin
                do_clear = 1'b1;
                armed_next = 1'b0;
            end
            PTC_RST_EACH: do_clear = rst_rise;
            default: do_clear = 1'b0;
        endcase
        // a new recording re-arms even when a pulse consumes the old arming
        if (rec_start_i) armed_next = 1'b1;
        // only reset pulses load the reference angle; recording start loads zero
        do_refload = do_clear && cfg_i.angle_mode &&
            (cfg_i.rst_mode == PTC_RST_FIRST || cfg_i.rst_mode == PTC_RST_EACH);
    end

    // counter, angle wrap and interval measurement
    always_comb begin
        logic [31:0] stepped;
        logic [31:0] maxa;
        stepped = cnt_reg + {{30{step[1]}}, step};
        maxa = {17'h0, cfg_i.max_angle}; // 15 bits caps it at 32767
        cnt_next = stepped;
        if (cfg_i.angle_mode) begin
            if (step == 2'sd1 && stepped >= maxa) cnt_next = 32'h0;
            else if (step == -2'sd1 && cnt_reg == 32'h0) cnt_next = maxa - 32'h1;
        end
        if (do_refload) cnt_next = {17'h0, cfg_i.ref_angle};
        else if (do_clear) cnt_next = `PTC_CNT_RESET;
        tick_next = tick_reg + 32'h1;
        t_first_next = t_first_reg;
        t_last_next = t_last_reg;
        c_first_next = c_first_reg;
        got_edge_next = got_edge_reg;
        if (step != 2'sd0) begin
            if (!got_edge_reg) begin
                t_first_next = tick_reg;
                c_first_next = cnt_reg;
            end
            t_last_next = tick_reg;
            got_edge_next = 1'b1;
        end
        smp_next = smp_reg;
        res_next = res_reg;
        res_next.valid = 1'b0;
        res_next.count = cnt_next;
        neg_next = neg_reg;
        if (sample_i) begin
            smp_next = smp_reg + 16'h1;
            if (smp_next >= ((cfg_i.interval == 16'h0) ? 16'h1 : cfg_i.interval)) begin
                smp_next = 16'h0;
                res_next.valid = 1'b1;
                res_next.delta = cnt_reg - c_first_reg;
                // an interval with no edge reports no span rather than a stale one
                res_next.dt_ticks = got_edge_reg ? t_last_reg - t_first_reg : 32'h0;
                neg_next = $signed(cnt_reg - c_first_reg) < 0;
                // the next interval starts here; an edge in this cycle opens it
                c_first_next = cnt_reg;
                t_first_next = tick_reg;
                got_edge_next = (step != 2'sd0);
            end
        end
    end

    // state registers
    always_ff @(posedge core_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sig_d_reg <= 1'b0;
            rst_d_reg <= 1'b0;
            dir_d_reg <= 1'b0;
            cnt_reg <= `PTC_CNT_RESET;
            armed_reg <= 1'b0;
            smp_reg <= 16'h0;
            tick_reg <= 32'h0;
            t_first_reg <= 32'h0;
            t_last_reg <= 32'h0;
            c_first_reg <= 32'h0;
            got_edge_reg <= 1'b0;
            res_reg <= '0;
            neg_reg <= 1'b0;
        end else begin
            sig_d_reg <= filt[2];
            rst_d_reg <= filt[1];
            dir_d_reg <= filt[0];
            cnt_reg <= cnt_next;
            armed_reg <= armed_next;
            smp_reg <= smp_next;
            tick_reg <= tick_next;
            t_first_reg <= t_first_next;
            t_last_reg <= t_last_next;
            c_first_reg <= c_first_next;
            got_edge_reg <= got_edge_next;
            res_reg <= res_next;
            neg_reg <= neg_next;
        end
    end
    assign result_o = res_reg;
    assign dir_neg_o = neg_reg;

    // checks
    property p_bi_up;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cfg_i.coupling == PTC_BI && sig_rise && !filt[0] && !do_clear && !cfg_i.angle_mode)
        |=> cnt_reg == $past(cnt_reg) + 32'h1;
    endproperty
    a_bi_up: assert property (p_bi_up) else $error("bi count up failed");
    property p_bi_dn;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cfg_i.coupling == PTC_BI && sig_rise && filt[0] && !do_clear && !cfg_i.angle_mode)
        |=> cnt_reg == $past(cnt_reg) - 32'h1;
    endproperty
    a_bi_dn: assert property (p_bi_dn) else $error("bi count down failed");
    property p_uni;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cfg_i.coupling == PTC_UNI && sig_rise && !do_clear && !cfg_i.angle_mode)
        |=> cnt_reg == $past(cnt_reg) + 32'h1;
    endproperty
    a_uni: assert property (p_uni) else $error("uni ignores direction wrongly");
    property p_start;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cfg_i.rst_mode == PTC_RST_START && rec_start_i) |=> cnt_reg == 32'h0;
    endproperty
    a_start: assert property (p_start) else $error("start reset missed");
    property p_each;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cfg_i.rst_mode == PTC_RST_EACH && rst_rise && !cfg_i.angle_mode) |=> cnt_reg == 32'h0;
    endproperty
    a_each: assert property (p_each) else $error("pulse reset missed");
    property p_first;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cfg_i.rst_mode == PTC_RST_FIRST && rst_rise && armed_reg && !rec_start_i)
        |=> !armed_reg;
    endproperty
    a_first: assert property (p_first) else $error("first pulse not consumed");
    property p_manual;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cfg_i.rst_mode == PTC_RST_MANUAL && !sw_clear_i && step == 2'sd0)
        |=> cnt_reg == $past(cnt_reg);
    endproperty
    a_manual: assert property (p_manual) else $error("count moved without cause");
    property p_wrap;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (cfg_i.angle_mode && !do_clear && cfg_i.max_angle != 15'h0)
        |=> cnt_reg < {17'h0, $past(cfg_i.max_angle)};
    endproperty
    a_wrap: assert property (p_wrap) else $error("angle beyond maximum");
endmodule

// [ptc_enc_model.sv]
// pulse source model: encoder or speed sensor on the counter pins
`timescale 1ns/10ps
module ptc_enc_model
    import ptc_pkg::*;
(
    input wire logic clk_i,
    output ptc_pins_t pins_o
);
    // lines rest low until the bench asks for activity
    initial pins_o = '0;

    // drive a level just after the edge and hold it n clocks
    task automatic hold(input ptc_pins_t v, input int n);
        pins_o <= v;
        repeat (n) @(posedge clk_i);
    endtask

    // one signal pulse; dir is set w clocks early and never toggled
    task automatic pulse_sig(input logic d, input int w);
        hold('{1'b0, pins_o.rst, d}, w);
        hold('{1'b1, pins_o.rst, d}, w);
        hold('{1'b0, pins_o.rst, d}, w);
    endtask

    // quadrature steps, phases a quarter cycle apart
    task automatic quad(input int n, input logic up, input int w);
        logic [1:0] ph [4];
        ph = '{2'b00, 2'b10, 2'b11, 2'b01};
        for (int i = 1; i <= 4 * n; i++) begin
            int k = up ? i % 4 : (4 - i % 4) % 4;
            hold('{ph[k][1], pins_o.rst, ph[k][0]}, w);
        end
    endtask
endmodule

// [tb_top.sv]
// self-checking bench for the pulse timer/counter input
`timescale 1ns/10ps
`include "ptc_defines.svh"
module tb_top;
    import ptc_pkg::*;
    logic core_clk_i = 1'b0; // 20 MHz core clock
    logic rst_n_i = 1'b0; // async reset, low at start
    ptc_pins_t pins; // driven by the source model
    ptc_cfg_t cfg; // configuration levels
    logic sample = 1'b0; // sample period strobe
    logic rec_start = 1'b0; // recording start strobe
    logic sw_clear = 1'b0; // software clear strobe
    ptc_result_t res; // block results
    logic dir_neg; // last interval ran downward
    int errors = 0;
    int checks = 0;
    int seed = 32'hda40;
    int exp_cnt = 0; // reference count
    int n; // random pulse count
    int thr [6] = '{`PTC_FLT_100NS, `PTC_FLT_200NS, `PTC_FLT_500NS,
        `PTC_FLT_1US, `PTC_FLT_2US, `PTC_FLT_5US};

    // free-running clock
    always #(`PTC_CLK_PERIOD_NS / 2) core_clk_i = ~core_clk_i;

    ptc_counter dut_u (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
        .pins_i(pins), .cfg_i(cfg), .sample_i(sample),
        .rec_start_i(rec_start), .sw_clear_i(sw_clear), .result_o(res),
        .dir_neg_o(dir_neg));
    ptc_enc_model enc_u (.clk_i(core_clk_i), .pins_o(pins));

    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk_i);
    endtask

    // compare one result value, counting every comparison
    task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask

    // let the count settle, sample it mid-cycle to avoid edge races
    task automatic chk_cnt();
        cyc(3);
        @(negedge core_clk_i);
        chk_val("count", exp_cnt, res.count);
        @(posedge core_clk_i);
    endtask

    // one-cycle strobe on control inputs; bits are sample, rec_start, sw_clear
    task automatic strobe(input logic [2:0] s);
        {sample, rec_start, sw_clear} <= s;
        cyc(1);
        {sample, rec_start, sw_clear} <= 3'h0;
        cyc(1);
    endtask

    // close an interval, then compare delta, edge span and sign;
    // valid stands one cycle only, so look right after the sampling edge
    task automatic interval(input int dl, input int dt);
        sample <= 1'b1;
        @(posedge core_clk_i);
        sample <= 1'b0;
        repeat (4) begin
            @(negedge core_clk_i);
            if (res.valid === 1'b1) break;
        end
        chk_val("valid", 1, res.valid);
        chk_val("delta", dl, res.delta);
        chk_val("dt_ticks", dt, res.dt_ticks);
        chk_val("dir_neg", dl < 0, dir_neg);
        @(posedge core_clk_i);
    endtask

    task automatic results();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    // watchdog: far beyond the fewer than two thousand cycles the run needs
    initial begin
        #(20000 * `PTC_CLK_PERIOD_NS);
        errors++;
        results();
    end

    initial begin
        cfg = '0;
        cfg.interval = 16'h0001;
        cyc(10);
        rst_n_i <= 1'b1;
        cyc(2);
        chk_cnt();
        // uni: dir held high must not matter, one-clock glitches are dropped
        n = ($random(seed) & 7) + 1;
        repeat (n) enc_u.pulse_sig(1'b1, 3);
        repeat (2) enc_u.pulse_sig(1'b1, 1);
        exp_cnt = n;
        chk_cnt();
        // every threshold: one pulse a clock too short, one long enough
        for (int f = 0; f < 6; f++) begin
            cfg.filter_sel <= f[2:0];
            cyc(2);
            enc_u.pulse_sig(1'b1, thr[f] / `PTC_CLK_PERIOD_NS - 1);
            enc_u.pulse_sig(1'b1, thr[f] / `PTC_CLK_PERIOD_NS + 2);
            exp_cnt++;
            chk_cnt();
        end
        cfg.filter_sel <= 3'h0;
        // manual: reset pin ignored, software clear honoured
        enc_u.hold('{1'b0, 1'b1, 1'b1}, 4);
        enc_u.hold('{1'b0, 1'b0, 1'b1}, 4);
        chk_cnt();
        strobe(3'h1);
        exp_cnt = 0;
        chk_cnt();
        // bi: down while dir high, up while low
        cfg.coupling <= PTC_BI;
        strobe(3'h4);
        cyc(3);
        repeat (3) enc_u.pulse_sig(1'b1, 3);
        interval(-3, 18);
        repeat (2) enc_u.pulse_sig(1'b0, 3);
        interval(2, 9);
        exp_cnt = -1;
        chk_cnt();
        interval(0, 0);
        // two samples per interval: both pulses land in one result
        cfg.interval <= 16'h0002;
        enc_u.pulse_sig(1'b0, 3);
        strobe(3'h4);
        enc_u.pulse_sig(1'b0, 3);
        interval(2, 11);
        // reset options
        cfg.coupling <= PTC_UNI;
        cfg.rst_mode <= PTC_RST_START;
        strobe(3'h2);
        exp_cnt = 0;
        chk_cnt();
        cfg.rst_mode <= PTC_RST_FIRST;
        strobe(3'h2);
        for (int p = 0; p < 2; p++) begin
            repeat (3) enc_u.pulse_sig(1'b0, 3);
            enc_u.hold('{1'b0, 1'b1, 1'b0}, 4);
            enc_u.hold('{1'b0, 1'b0, 1'b0}, 4);
            exp_cnt = p ? 3 : 0;
            chk_cnt();
        end
        // each pulse, inverted: clear is seen while the pin is still low
        cfg.rst_mode <= PTC_RST_EACH;
        cfg.rst_invert <= 1'b1;
        enc_u.hold('{1'b0, 1'b1, 1'b0}, 4);
        repeat (2) begin
            enc_u.hold('{1'b0, 1'b0, 1'b0}, 4);
            exp_cnt = 0;
            chk_cnt();
            enc_u.hold('{1'b0, 1'b1, 1'b0}, 4);
            enc_u.pulse_sig(1'b0, 3);
            exp_cnt = 1;
            chk_cnt();
        end
        // angle: reference load and wrap, small turn and the largest one
        cfg.angle_mode <= 1'b1;
        for (int a = 0; a < 2; a++) begin
            cfg.max_angle <= a ? 15'h7fff : 15'h0005;
            cfg.ref_angle <= a ? 15'h7ffe : 15'h0003;
            enc_u.hold('{1'b0, 1'b0, 1'b0}, 4);
            exp_cnt = a ? 32766 : 3;
            chk_cnt();
            enc_u.hold('{1'b0, 1'b1, 1'b0}, 4);
            repeat (3) enc_u.pulse_sig(1'b0, 3);
            exp_cnt = (exp_cnt + 3) % (a ? 32767 : 5);
            chk_cnt();
        end
        // quadrature: two turns forward, one back, four counts per step cycle
        cfg.angle_mode <= 1'b0;
        cfg.coupling <= PTC_QUAD;
        cfg.rst_mode <= PTC_RST_MANUAL;
        strobe(3'h1);
        enc_u.quad(2, 1'b1, 3);
        exp_cnt = 8;
        chk_cnt();
        enc_u.quad(1, 1'b0, 3);
        exp_cnt = 4;
        chk_cnt();
        results();
    end
endmodule
